// File: logic/cko_cfg.svh
// Purpose: Constants for the clock output and oscillator control block
// Assumes: 16 MHz reference clock drives the divider; 8-bit register port
// Notes:   Offsets are register addresses on the documented register port
`ifndef CKO_CFG_SVH
`define CKO_CFG_SVH
`define CKO_ADDR_PAD_CFG     6'h03
`define CKO_ADDR_RX_CFG      6'h0a
`define CKO_ADDR_OSC_CFG     6'h12
`define CKO_RST_PAD_CFG      8'h19
`define CKO_RST_RX_CFG       8'h17
`define CKO_RST_OSC_CFG      8'hf0
`define CKO_PAD_IO_HI        7
`define CKO_PAD_IO_LO        6
`define CKO_PAD_CLK_HI       5
`define CKO_PAD_CLK_LO       4
`define CKO_DEFER_BIT        3
`define CKO_RATE_HI          2
`define CKO_RATE_LO          0
`define CKO_JITTER_BIT       5
`define CKO_MODE_HI          7
`define CKO_MODE_LO          4
`define CKO_TRIM_HI          3
`define CKO_TRIM_LO          0
`define CKO_MODE_EXT_REF     4'h4
`define CKO_MODE_XTAL        4'hf
`define CKO_RATE_OFF         3'h0
`define CKO_RATE_SYMBOL      3'h7
`define CKO_SLEEP_TAIL_CYC   6'h23
// Half periods in reference cycles for each rate code
`define CKO_HALF_1M          11'h008
`define CKO_HALF_2M          11'h004
`define CKO_HALF_4M          11'h002
`define CKO_HALF_8M          11'h001
`define CKO_HALF_250K        11'h020
`define CKO_HALF_20K         11'h190
`define CKO_HALF_40K         11'h0c8
`define CKO_HALF_25K         11'h140
`define CKO_HALF_62K5        11'h080
`endif

// File: logic/cko_clock_ctrl.sv
// Purpose: Clock output, pad drive, jitter and oscillator configuration
// Assumes: clk is the 16 MHz reference; register port is a simple 8-bit strobe port
// Notes:   Active rate survives srst, only the register copy resets
//
// Overview of operation
// - Bits 5:4 of pad config set clock pin drive 2-8 mA, reset 1.
// - Bits 7:6 of pad config set other pads' drive, reset 0.
// - Bit 3 defers rate changes until after sleep; reset 1.
// - Rate code 0 stops the output clock and holds it low.
// - Codes 1-5 give 1,2,4,8,16 MHz, code 6 gives 250 kHz; reset 1.
// - Code 7 outputs the current symbol rate from modulation settings.
// - Symbol rate is 20/40 kHz or 25/62.5 kHz by modulation and submode.
// - Sleep request in idle at 1-16 MHz gives 35 more clock cycles.
// - Bit 5 of receiver config enables the jitter module, reset 0.
// - Jitter is forced off while transmitting or filter tuning.
// - Oscillator mode 0x4 selects external reference, 0xF the crystal.
// - Bits 3:0 of oscillator config give load trim, every code valid.
// - Rate change is immediate if defer is 0 or old rate 0.
// - Reset keeps the running rate; reads show 1; sleep then applies it.
// - Jitter reaches receiver and I/O only, never transmit or RF.
`timescale 1ns/1ns
`include "cko_cfg.svh"
// Register map
//   Pad config holds both pad drive fields, the defer bit and the rate code.
//   Receiver config holds the jitter enable; its other bits are plain storage.
//   Oscillator config holds the oscillator mode and the load trim.
//   Unmapped writes are dropped and unmapped reads return zero.
//
// Read path
//   Read data is registered, so it appears one cycle after the read strobe.
//   It then holds until the next read, which lets a slow host pick it up late.
//   A write and a read to one address in one cycle return the old contents.
//
// Rate shadow
//   The written rate code and the rate driving the divider are kept apart.
//   The divider always follows the active rate, never the register copy.
//   A write applies at once when deferral is off or the active rate was code 0.
//   Otherwise the new code waits in the register until sleep is left.
//   Reset reloads the register copy with its reset value but keeps the active rate, so a host
//   fed by the output clock gets the same rate back once a reset of this block ends.
//   Limitation: at power-up the active rate is unknown until the first
//   immediate write or the first wake; software must write the rate first.
//
// Sleep sequence
//   The sleep pin comes from another domain and passes a four-flop chain.
//   The chain adds four cycles of latency, which is longer than the two-cycle
//   period of the fastest divided rate that earns a tail.
//   With the radio idle and a rate between 1 and 16 MHz, the block counts
//   35 rising edges of the output clock before stopping it.
//   Other rates, including the symbol rate, stop at once.
//   Dropping the pin wakes the block and loads the rate from the register.
//   Trade-off: the tail counts divider edge markers rather than pin edges,
//   so the count stays in the block clock domain with no extra crossing.
//
// Jitter controls
//   Jitter enable is gated off while transmitting or tuning filters.
//   The receive and I/O enables are the same gated signal.
//   The transmit enable is tied low; jitter never reaches transmit or RF.
//
// Oscillator controls
//   The mode field is decoded into crystal, external reference or reserved.
//   Reserved codes enable neither path; the flag lets the host spot them.
//   Every trim code is legal and is passed straight to the capacitor array.
//
// Hazards
//   The 16 MHz code passes the reference itself, so that output is gated
//   combinationally; every slower rate leaves a flip-flop.
//   The divider compares its count against the live half period every cycle,
//   so a rate change can cut a high phase short.
module cko_clock_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Radio state inputs, same clock domain
  input  wire logic       radio_idle_state,
  input  wire logic       tx_active,
  input  wire logic       filter_tuning,
  input  wire logic       modulation_select,
  input  wire logic       sub_mode,
  // Sleep trigger pin, asynchronous
  input  wire logic       sleep_tx_trigger,
  // Clock output pin and pad controls
  output logic            divided_clock_out,
  output logic      [1:0] clkout_pad_drive,
  output logic      [1:0] dig_pad_drive,
  // Power and jitter controls
  output logic            sleep_enter,
  output logic            rx_jitter_on,
  output logic            io_jitter_on,
  output logic            tx_jitter_on,
  // Oscillator controls
  output logic            crystal_osc_enable,
  output logic            ext_ref_select,
  output logic            osc_mode_reserved,
  output logic      [3:0] osc_load_trim
);
  cko_pkg::cko_state_s   st;
  cko_pkg::cko_state_s   next_st;
  cko_pkg::cko_div_cfg_s div_cfg;
  logic                  div_rise;
  logic                  slp_req;
  logic                  tail_rate;

  // Field helpers used by write and sleep logic
  function automatic logic [2:0] rate_of(input logic [7:0] r);
    rate_of = r[`CKO_RATE_HI:`CKO_RATE_LO];
  endfunction

  assign slp_req   = st.slp_sync[1];
  // Rates 1..16 MHz earn the extra tail cycles
  assign tail_rate = (st.active_rate >= 3'h1) && (st.active_rate <= 3'h5);

  // Register, rate shadow and sleep sequencing
  always_comb begin
    next_st          = st;
    next_st.slp_meta = {st.slp_meta[0], sleep_tx_trigger};
    next_st.slp_sync = {st.slp_sync[0], st.slp_meta[1]};
    if (reg_wr) begin
      case (reg_addr)
        `CKO_ADDR_PAD_CFG: begin
          next_st.pad_cfg = reg_wdata;
          if (!reg_wdata[`CKO_DEFER_BIT] || st.active_rate == `CKO_RATE_OFF) begin
            next_st.active_rate = rate_of(reg_wdata);
          end
        end
        `CKO_ADDR_RX_CFG:  next_st.rx_cfg  = reg_wdata;
        `CKO_ADDR_OSC_CFG: next_st.osc_cfg = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CKO_ADDR_PAD_CFG: next_st.rdata = st.pad_cfg;
        `CKO_ADDR_RX_CFG:  next_st.rdata = st.rx_cfg;
        `CKO_ADDR_OSC_CFG: next_st.rdata = st.osc_cfg;
        default:           next_st.rdata = 8'h00;
      endcase
    end
    case (st.pwr)
      cko_pkg::CKO_RUN: begin
        if (slp_req && radio_idle_state) begin
          next_st.tail_cnt = 6'h00;
          next_st.pwr      = tail_rate ? cko_pkg::CKO_TAIL : cko_pkg::CKO_SLEEP;
        end
      end
      cko_pkg::CKO_TAIL: begin
        // Count output rising edges before stopping the clock
        if (div_rise) begin
          next_st.tail_cnt = st.tail_cnt + 6'h01;
          if (st.tail_cnt + 6'h01 == `CKO_SLEEP_TAIL_CYC) begin
            next_st.pwr = cko_pkg::CKO_SLEEP;
          end
        end
      end
      cko_pkg::CKO_SLEEP: begin
        if (!slp_req) begin
          next_st.pwr         = cko_pkg::CKO_RUN;
          next_st.active_rate = rate_of(next_st.pad_cfg);
        end
      end
      default: next_st.pwr = cko_pkg::CKO_RUN;
    endcase
  end

  // Registers; active rate deliberately survives srst so the pin resumes that rate after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st.pad_cfg  <= `CKO_RST_PAD_CFG;
      st.rx_cfg   <= `CKO_RST_RX_CFG;
      st.osc_cfg  <= `CKO_RST_OSC_CFG;
      st.pwr      <= cko_pkg::CKO_RUN;
      st.tail_cnt <= 6'h00;
      st.slp_sync <= 2'b00;
      st.slp_meta <= 2'b00;
      st.rdata    <= 8'h00;
      st.active_rate <= next_st.active_rate;
    end else begin
      st <= next_st;
    end
  end

  // Divider sees the live rate, stopped during sleep
  always_comb begin
    div_cfg          = '0;
    div_cfg.rate     = st.active_rate;
    div_cfg.mod_sel  = modulation_select;
    div_cfg.sub_mode = sub_mode;
    div_cfg.run      = (st.pwr != cko_pkg::CKO_SLEEP);
  end

  cko_divider u_div (
    .clk     (clk),
    .srst    (srst),
    .cfg     (div_cfg),
    .clk_out (divided_clock_out),
    .rise    (div_rise)
  );

  // Output decode
  assign reg_rdata          = st.rdata;
  assign clkout_pad_drive   = st.pad_cfg[`CKO_PAD_CLK_HI:`CKO_PAD_CLK_LO];
  assign dig_pad_drive      = st.pad_cfg[`CKO_PAD_IO_HI:`CKO_PAD_IO_LO];
  assign sleep_enter        = (st.pwr == cko_pkg::CKO_SLEEP);
  // Jitter never reaches the transmit path or RF synthesis
  assign rx_jitter_on       = st.rx_cfg[`CKO_JITTER_BIT] && !tx_active && !filter_tuning;
  assign io_jitter_on       = rx_jitter_on;
  assign tx_jitter_on       = 1'b0;
  assign crystal_osc_enable = (st.osc_cfg[`CKO_MODE_HI:`CKO_MODE_LO] == `CKO_MODE_XTAL);
  assign ext_ref_select     = (st.osc_cfg[`CKO_MODE_HI:`CKO_MODE_LO] == `CKO_MODE_EXT_REF);
  assign osc_mode_reserved  = !crystal_osc_enable && !ext_ref_select;
  assign osc_load_trim      = st.osc_cfg[`CKO_TRIM_HI:`CKO_TRIM_LO];
endmodule

// File: logic/cko_divider.sv
// Purpose: Divides the 16 MHz reference to the selected output rate
// Assumes: clk is the 16 MHz reference
// Notes:   Rate changes take effect at any phase, so a runt pulse can appear
`timescale 1ns/1ns
`include "cko_cfg.svh"
module cko_divider (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Configuration
  input  wire cko_pkg::cko_div_cfg_s cfg,
  // Output clock and its rising edge marker
  output logic                   clk_out,
  output logic                   rise
);
  cko_pkg::cko_div_state_s st;
  cko_pkg::cko_div_state_s next_st;

  // Half period per rate code; 16 MHz passes the reference straight through
  function automatic logic [10:0] half_of(input cko_pkg::cko_div_cfg_s c);
    case (c.rate)
      3'h1:    half_of = `CKO_HALF_1M;
      3'h2:    half_of = `CKO_HALF_2M;
      3'h3:    half_of = `CKO_HALF_4M;
      3'h4:    half_of = `CKO_HALF_8M;
      3'h6:    half_of = `CKO_HALF_250K;
      3'h7:    half_of = c.mod_sel ? (c.sub_mode ? `CKO_HALF_62K5 : `CKO_HALF_25K)
                                   : (c.sub_mode ? `CKO_HALF_40K : `CKO_HALF_20K);
      default: half_of = 11'h001;
    endcase
  endfunction

  // Toggle counter
  always_comb begin
    next_st        = st;
    next_st.edge_q = 1'b0;
    if (!cfg.run || cfg.rate == `CKO_RATE_OFF) begin
      next_st.clk_q = 1'b0;
      next_st.cnt   = 11'h000;
    end else if (st.cnt + 11'h001 >= half_of(cfg)) begin
      next_st.cnt    = 11'h000;
      next_st.clk_q  = ~st.clk_q;
      next_st.edge_q = ~st.clk_q;
    end else begin
      next_st.cnt = st.cnt + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // 16 MHz code gates the reference itself
  assign clk_out = (cfg.run && cfg.rate == 3'h5) ? clk : st.clk_q;
  assign rise    = (cfg.run && cfg.rate == 3'h5) ? 1'b1 : st.edge_q;
endmodule

// File: logic/cko_pkg.sv
// Purpose: Types for the clock output and oscillator control block
// Assumes: Constants come from cko_cfg.svh
// Notes:   Types only
package cko_pkg;
  typedef enum logic [1:0] {
    CKO_RUN   = 2'b00,
    CKO_TAIL  = 2'b01,
    CKO_SLEEP = 2'b10
  } cko_pwr_e;

  typedef struct packed {
    logic [7:0] pad_cfg;
    logic [7:0] rx_cfg;
    logic [7:0] osc_cfg;
    logic [2:0] active_rate;
    cko_pwr_e   pwr;
    logic [5:0] tail_cnt;
    logic [1:0] slp_sync;
    logic [1:0] slp_meta;
    logic [7:0] rdata;
  } cko_state_s;

  typedef struct packed {
    logic [2:0] rate;
    logic       mod_sel;
    logic       sub_mode;
    logic       run;
  } cko_div_cfg_s;

  typedef struct packed {
    logic [10:0] cnt;
    logic        clk_q;
    logic        edge_q;
  } cko_div_state_s;
endpackage

// File: sim/cko_clock_ctrl_sva.sv
// Purpose: Port checks for the clock output control block
// Assumes: Bound to cko_clock_ctrl
// Notes:   Register effects are seen one cycle after the write
`timescale 1ns/1ns
module cko_clock_ctrl_sva (
  // Clock, reset, register port
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [5:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Radio state
  input wire logic       tx_active,
  input wire logic       filter_tuning,
  // Controls
  input wire logic [1:0] clkout_pad_drive,
  input wire logic [1:0] dig_pad_drive,
  input wire logic       rx_jitter_on,
  input wire logic       io_jitter_on,
  input wire logic       tx_jitter_on,
  input wire logic       crystal_osc_enable,
  input wire logic       ext_ref_select,
  input wire logic [3:0] osc_load_trim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Pad fields follow writes; reset values seen as reset drops
  pad_drive_a: assert property (reg_wr && reg_addr == 6'h03 |=>
    clkout_pad_drive == $past(reg_wdata[5:4])) else $error("clock pad drive wrong");
  io_drive_a: assert property (reg_wr && reg_addr == 6'h03 |=>
    dig_pad_drive == $past(reg_wdata[7:6])) else $error("io pad drive wrong");
  reset_vals_a: assert property ($fell(srst) |-> clkout_pad_drive == 2'h1 &&
    dig_pad_drive == 2'h0 && !rx_jitter_on && crystal_osc_enable && osc_load_trim == 4'h0)
    else $error("reset outputs wrong");
  // Jitter gating
  jitter_off_a: assert property (tx_active || filter_tuning |->
    !rx_jitter_on && !io_jitter_on) else $error("jitter not forced off");
  tx_clean_a: assert property (!tx_jitter_on) else $error("jitter on transmit");
  // Oscillator fields, then pad read-back
  osc_trim_a: assert property (reg_wr && reg_addr == 6'h12 |=>
    osc_load_trim == $past(reg_wdata[3:0])) else $error("trim wrong");
  ext_ref_a: assert property (reg_wr && reg_addr == 6'h12 && reg_wdata[7:4] == 4'h4 |=>
    ext_ref_select && !crystal_osc_enable) else $error("external mode wrong");
  rd_pads_a: assert property (reg_rd && !reg_wr && reg_addr == 6'h03 |=>
    reg_rdata[7:4] == {dig_pad_drive, clkout_pad_drive}) else $error("pad read wrong");
endmodule

// File: sim/cko_mcu_model.sv
// Purpose: Microcontroller stand-in clocked by the divided output
// Assumes: It only counts the rising edges it receives
// Notes:   The count runs apart from the block clock
`timescale 1ns/1ns
module cko_mcu_model (
  // Received clock and count clear
  input  wire logic mclk,
  input  wire logic clr,
  // Edges since the last clear
  output int        edges
);
  // Async clear, because the clock may be stopped
  always @(posedge mclk or posedge clr) begin
    if (clr) begin
      edges <= 0;
    end else begin
      edges <= edges + 1;
    end
  end
endmodule

// File: sim/tb_cko_clock_ctrl.sv
// Purpose: Self-checking bench for the clock output control block
// Assumes: Edge counts over a window stand in for frequency
// Notes:   Counts allow one edge of slack for window phase, except the exact off and tail counts
`timescale 1ns/1ns
module tb_cko_clock_ctrl;
  localparam int WIN = 3200;
  logic       clk, srst, reg_wr, reg_rd, radio_idle_state, tx_active, filter_tuning, clr;
  logic       modulation_select, sub_mode, sleep_tx_trigger, divided_clock_out, sleep_enter;
  logic       rx_jitter_on, io_jitter_on, tx_jitter_on, crystal_osc_enable;
  logic       ext_ref_select, osc_mode_reserved;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_q;
  logic [1:0] clkout_pad_drive, dig_pad_drive;
  logic [3:0] osc_load_trim;
  int         edges, base, n, fails, total_checks;
  cko_clock_ctrl cko_clock_ctrl_i (.clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .radio_idle_state, .tx_active, .filter_tuning, .modulation_select,
    .sub_mode, .sleep_tx_trigger, .divided_clock_out, .clkout_pad_drive, .dig_pad_drive,
    .sleep_enter, .rx_jitter_on, .io_jitter_on, .tx_jitter_on, .crystal_osc_enable,
    .ext_ref_select, .osc_mode_reserved, .osc_load_trim);
  cko_mcu_model cko_mcu_model_i (.mclk(divided_clock_out), .clr, .edges);
  // 10 MHz clock
  always #50 clk = ~clk;
  // Inputs move 10 ns after the edge
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chkn(string what, int exp, int got, int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      fails++;
      $display("FAIL %s exp %0d got %0d", what, exp, got);
    end
  endtask
  // One register access; a spare cycle keeps strobes apart
  task automatic acc(logic w, logic [5:0] a, logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    step(1);
    rd_q = reg_rdata;
    {reg_wr, reg_rd} = 2'b00;
    step(1);
  endtask
  task automatic meas(string what, int period, int tol);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(WIN);
    chkn(what, WIN / period, edges, tol);
  endtask
  task automatic s_reset_vals;
    logic [5:0] a[4] = '{6'h03, 6'h0a, 6'h12, 6'h3f};
    logic [7:0] v[4] = '{8'h19, 8'h17, 8'hf0, 8'h00};
    foreach (a[i]) begin
      acc(1'b0, a[i], 8'h00);
      chk8("reset read", v[i], rd_q);
    end
  endtask
  task automatic s_drive;
    for (int d = 3; d >= 0; d--) begin
      acc(1'b1, 6'h03, {2'(3 - d), 2'(d), 4'h1});
      chk8("clock pad", 8'(d), {6'h0, clkout_pad_drive});
      chk8("io pad", 8'(3 - d), {6'h0, dig_pad_drive});
    end
  endtask
  // Periods in block cycles; the last four are code 7
  task automatic s_rates;
    int per[10] = '{16, 8, 4, 2, 1, 64, 800, 400, 640, 256};
    for (int i = 0; i < 10; i++) begin
      {modulation_select, sub_mode} = (i > 6) ? 2'(i - 6) : 2'h0;
      acc(1'b1, 6'h03, 8'(i < 6 ? i + 1 : 7));
      step(900);
      meas("rate edges", per[i], 1);
    end
  endtask
  task automatic s_off;
    acc(1'b1, 6'h03, 8'h00);
    step(900);
    meas("off edges", WIN + 1, 0);
    chk8("off level", 8'h00, {7'h0, divided_clock_out});
    acc(1'b1, 6'h03, 8'h0b);
    step(900);
    meas("from off", 4, 1);
  endtask
  task automatic s_jitter;
    acc(1'b1, 6'h0a, 8'h37);
    acc(1'b0, 6'h0a, 8'h00);
    chk8("rx cfg", 8'h37, rd_q);
    for (int k = 0; k < 4; k++) begin
      {tx_active, filter_tuning} = 2'(k);
      step(1);
      chk8("jitter", {6'h0, k == 0, k == 0}, {6'h0, rx_jitter_on, io_jitter_on});
    end
    chk8("tx jitter", 8'h00, {7'h0, tx_jitter_on});
  endtask
  // Last value leaves the external reference mode in place
  task automatic s_osc;
    logic [7:0] v[3] = '{8'hff, 8'h50, 8'h4a};
    logic [2:0] e[3] = '{3'b100, 3'b001, 3'b010};
    foreach (v[i]) begin
      acc(1'b1, 6'h12, v[i]);
      chk8("osc mode", {5'h0, e[i]}, {5'h0, crystal_osc_enable, ext_ref_select,
        osc_mode_reserved});
      chk8("osc trim", {4'h0, v[i][3:0]}, {4'h0, osc_load_trim});
    end
  endtask
  // Rate survives reset; deferred rate lands after sleep
  task automatic s_sleep;
    acc(1'b1, 6'h03, 8'h05);
    srst = 1'b1;
    step(1);
    srst = 1'b0;
    acc(1'b0, 6'h03, 8'h00);
    chk8("pad cfg", 8'h19, rd_q);
    meas("kept rate", 1, 1);
    acc(1'b1, 6'h03, 8'h01);
    acc(1'b1, 6'h03, 8'h0c);
    step(900);
    meas("deferred", 16, 1);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    for (n = 0; n < 40 && edges == 0; n++) step(1);
    if (n == 40) begin
      fails++;
      end_sim();
    end
    sleep_tx_trigger = 1'b1;
    base = edges;
    for (n = 0; n < 700 && sleep_enter !== 1'b1; n++) step(1);
    if (n == 700) begin
      fails++;
      end_sim();
    end
    chkn("tail edges", 35, edges - base, 0);
    step(200);
    chkn("asleep", 35, edges - base, 0);
    sleep_tx_trigger = 1'b0;
    step(900);
    meas("woken", 2, 1);
  endtask
  initial begin
    {srst, clr, radio_idle_state} = 3'b111;
    {clk, reg_wr, reg_rd, tx_active, filter_tuning} = 5'h0;
    {modulation_select, sub_mode, sleep_tx_trigger, reg_addr, reg_wdata} = 17'h0;
    step(16);
    srst = 1'b0;
    s_reset_vals();
    s_drive();
    s_rates();
    s_off();
    s_jitter();
    s_osc();
    s_sleep();
    end_sim();
  end
endmodule
bind cko_clock_ctrl cko_clock_ctrl_sva cko_clock_ctrl_sva_i (.clk, .srst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_active, .filter_tuning, .clkout_pad_drive,
  .dig_pad_drive, .rx_jitter_on, .io_jitter_on, .tx_jitter_on, .crystal_osc_enable,
  .ext_ref_select, .osc_load_trim);
